/* core/mpa_pkg.sv */
// Constants, register map and types for the port A block
package mpa_pkg;

  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PORT_A_DATA = 10'h005;
  localparam logic [IDX_W-1:0] IDX_PORT_A_DIRECTION = 10'h085;
  localparam logic [IDX_W-1:0] IDX_ANALOG_PIN_SELECT = 10'h09d;

  // Field layout of the analog pin select register
  localparam int ASEL_W = 6;
  localparam int ASEL_LOW_LSB = 0;
  localparam int ASEL_LOW_W = 4;
  localparam int ASEL_PB_LSB = 4;
  localparam int ASEL_PB_W = 2;

  // Pin positions inside port A
  localparam int PIN_OPEN_DRAIN = 4;
  localparam int PIN_INPUT_ONLY = 5;
  localparam int PIN_OSC_OUT = 6;
  localparam int PIN_OSC_IN = 7;
  localparam int PORT_W = 8;

  // Reset values
  localparam logic [3:0] RST_DATA_LOW = 4'h0;
  localparam logic [PORT_W-1:0] RST_DATA = 8'h00;
  localparam logic [PORT_W-1:0] RST_DIRECTION = 8'hff;
  localparam logic [ASEL_W-1:0] RST_ASEL = 6'h3f;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MPA_WS_COLLECT = 2'b01,
    MPA_WS_RESP = 2'b10
  } mpa_wstate_e;

  typedef enum logic [1:0] {
    MPA_PK_PUSH_PULL = 2'h0,
    MPA_PK_OPEN_DRAIN = 2'h1,
    MPA_PK_INPUT_ONLY = 2'h2
  } mpa_pin_kind_e;

endpackage

/* core/mpa_pin_cell.sv */
// One port pin: input synchroniser, driver control and read level
`timescale 1ns/100ps
`default_nettype none
module mpa_pin_cell #(
  parameter mpa_pkg::mpa_pin_kind_e KIND = mpa_pkg::MPA_PK_PUSH_PULL
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic padIn,
  input wire logic dirInput,
  input wire logic latchBit,
  input wire logic analogMode,
  input wire logic portBlocked,
  output logic padOut,
  output logic padOe,
  output logic pinLevel,
  output logic padSync
);
  import mpa_pkg::*;

  logic meta_ff;
  logic sync_ff;
  logic padOut_ff;
  logic padOe_ff;
  logic nxt_padOut;
  logic nxt_padOe;
  logic driveWanted;

  // Direction still applies in analog mode; a cleared bit drives
  assign driveWanted = ~dirInput & ~portBlocked;
  // Open drain only pulls low; input-only pin has no driver
  assign nxt_padOe = (KIND == MPA_PK_INPUT_ONLY) ? 1'b0 :
    (KIND == MPA_PK_OPEN_DRAIN) ? (driveWanted & ~latchBit) :
    driveWanted;
  assign nxt_padOut = (KIND == MPA_PK_OPEN_DRAIN) ? 1'b0 : latchBit;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      padOut_ff <= 1'b0;
      padOe_ff <= 1'b0;
    end else begin
      meta_ff <= padIn;
      sync_ff <= meta_ff;
      padOut_ff <= nxt_padOut;
      padOe_ff <= nxt_padOe;
    end
  end

  // Input buffer off in analog mode, so the pin reads low
  assign pinLevel = analogMode ? 1'b0 : sync_ff;
  assign padSync = sync_ff;
  assign padOut = padOut_ff;
  assign padOe = padOe_ff;

endmodule
`default_nettype wire

/* core/mpa_port_a.sv */
// Port A with analog pin select, registers on AXI4-Lite
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module mpa_port_a (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic otherResetPin,
  input wire logic oscUsesOutPin,
  input wire logic oscUsesInPin,
  input wire logic [mpa_pkg::PORT_W-1:0] periphEnable,
  input wire logic [mpa_pkg::PORT_W-1:0] padIn,
  output logic [mpa_pkg::PORT_W-1:0] padOut,
  output logic [mpa_pkg::PORT_W-1:0] padOe,
  output logic timer0ExternalClockIn,
  output logic masterClearIn,
  output logic [mpa_pkg::ASEL_LOW_W-1:0] lowerAnalogMode,
  output logic [mpa_pkg::ASEL_PB_W-1:0] portBAnalogMode,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [mpa_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [mpa_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [mpa_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [mpa_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  import mpa_pkg::*;

  // Register file
  logic [PORT_W-1:0] latch_ff;
  logic [PORT_W-1:0] dir_ff;
  logic [ASEL_W-1:0] aSel_ff;
  logic [PORT_W-1:0] nxt_latch;
  logic [PORT_W-1:0] nxt_dir;
  logic [ASEL_W-1:0] nxt_aSel;

  // Non-power-on reset request, synchronised
  logic otherRstMeta_ff;
  logic otherRstSync_ff;

  // Pin side
  logic [PORT_W-1:0] pinLevel;
  logic [PORT_W-1:0] padSync;
  logic [PORT_W-1:0] analogVec;
  logic [PORT_W-1:0] blockVec;
  logic timer0_ff;
  logic clrPin_ff;
  logic [ASEL_LOW_W-1:0] lowerAn_ff;
  logic [ASEL_PB_W-1:0] portBAn_ff;

  // Write channel
  mpa_wstate_e wState_ff;
  mpa_wstate_e nxt_wState;
  logic awHeld_ff;
  logic wHeld_ff;
  logic [IDX_W-1:0] awIdx_ff;
  logic [PORT_W-1:0] wData_ff;
  logic wLane0_ff;
  logic awReady_ff;
  logic wReady_ff;
  logic bValid_ff;
  logic [1:0] bResp_ff;
  logic nxt_awHeld;
  logic nxt_wHeld;
  logic awTake;
  logic wTake;
  logic doWrite;
  logic bDone;

  // Read channel
  logic arReady_ff;
  logic rValid_ff;
  logic [DATA_W-1:0] rData_ff;
  logic [1:0] rResp_ff;
  logic nxt_rValid;
  logic arTake;

  // Decode
  logic wrSelData;
  logic wrSelDir;
  logic wrSelASel;
  logic wrHit;
  logic [IDX_W-1:0] arIdx;
  logic rdSelData;
  logic rdSelDir;
  logic rdSelASel;
  logic rdHit;
  logic [PORT_W-1:0] rdByte;
  logic [PORT_W-1:0] laneMask;
  logic [PORT_W-1:0] rmwValue;
  logic otherRst;

  // Pin cells; pin kind follows its shared function
  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_pin
      mpa_pin_cell #(
        .KIND((gi == PIN_OPEN_DRAIN) ? MPA_PK_OPEN_DRAIN :
          (gi == PIN_INPUT_ONLY) ? MPA_PK_INPUT_ONLY :
          MPA_PK_PUSH_PULL)
      ) u_cell (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .padIn(padIn[gi]),
        .dirInput(dir_ff[gi]),
        .latchBit(latch_ff[gi]),
        .analogMode(analogVec[gi]),
        .portBlocked(blockVec[gi]),
        .padOut(padOut[gi]),
        .padOe(padOe[gi]),
        .pinLevel(pinLevel[gi]),
        .padSync(padSync[gi])
      );
    end
  endgenerate

  // Only the lower four port A pins are mixed-signal
  assign analogVec = {{(PORT_W - ASEL_LOW_W){1'b0}},
    aSel_ff[ASEL_LOW_LSB +: ASEL_LOW_W]};
  // Peripheral or oscillator use takes the pin from the port
  assign blockVec = periphEnable |
    {oscUsesInPin, oscUsesOutPin, {(PORT_W - 2){1'b0}}};

  assign otherRst = otherRstSync_ff;

  // Write path
  assign awTake = s_axi_awvalid & awReady_ff;
  assign wTake = s_axi_wvalid & wReady_ff;
  assign doWrite = (wState_ff == MPA_WS_COLLECT) & awHeld_ff & wHeld_ff;
  assign bDone = bValid_ff & s_axi_bready;
  assign nxt_awHeld = doWrite ? 1'b0 : (awHeld_ff | awTake);
  assign nxt_wHeld = doWrite ? 1'b0 : (wHeld_ff | wTake);

  always_comb begin
    case (wState_ff)
      MPA_WS_COLLECT: nxt_wState = doWrite ? MPA_WS_RESP : MPA_WS_COLLECT;
      MPA_WS_RESP: nxt_wState = bDone ? MPA_WS_COLLECT : MPA_WS_RESP;
      default: nxt_wState = MPA_WS_COLLECT;
    endcase
  end

  assign wrSelData = awIdx_ff == IDX_PORT_A_DATA;
  assign wrSelDir = awIdx_ff == IDX_PORT_A_DIRECTION;
  assign wrSelASel = awIdx_ff == IDX_ANALOG_PIN_SELECT;
  assign wrHit = wrSelData | wrSelDir | wrSelASel;

  // Pins are sampled and merged; an unstrobed lane writes them back
  assign laneMask = {PORT_W{wLane0_ff}};
  assign rmwValue = (pinLevel & ~laneMask) | (wData_ff & laneMask);

  // Other resets clear only the low data bits; upper bits hold
  assign nxt_latch = otherRst ? {latch_ff[PORT_W-1:4], RST_DATA_LOW} :
    (doWrite & wrSelData) ? rmwValue : latch_ff;
  assign nxt_dir = otherRst ? RST_DIRECTION :
    (doWrite & wrSelDir & wLane0_ff) ? wData_ff : dir_ff;
  // Reserved top bits are not stored at all
  assign nxt_aSel = otherRst ? RST_ASEL :
    (doWrite & wrSelASel & wLane0_ff) ? wData_ff[ASEL_W-1:0] :
    aSel_ff;

  // Read path
  assign arTake = s_axi_arvalid & arReady_ff;
  assign arIdx = s_axi_araddr[ADDR_W-1:2];
  assign rdSelData = arIdx == IDX_PORT_A_DATA;
  assign rdSelDir = arIdx == IDX_PORT_A_DIRECTION;
  assign rdSelASel = arIdx == IDX_ANALOG_PIN_SELECT;
  assign rdHit = rdSelData | rdSelDir | rdSelASel;
  assign rdByte = rdSelData ? pinLevel :
    rdSelDir ? dir_ff :
    rdSelASel ? {2'h0, aSel_ff} : 8'h00;
  assign nxt_rValid = arTake | (rValid_ff & ~s_axi_rready);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      otherRstMeta_ff <= 1'b0;
      otherRstSync_ff <= 1'b0;
    end else begin
      otherRstMeta_ff <= otherResetPin;
      otherRstSync_ff <= otherRstMeta_ff;
    end
  end

  // Power-on and brown-out: upper data bits are undefined, zero here
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_ff <= RST_DATA;
      dir_ff <= RST_DIRECTION;
      aSel_ff <= RST_ASEL;
    end else begin
      latch_ff <= nxt_latch;
      dir_ff <= nxt_dir;
      aSel_ff <= nxt_aSel;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wState_ff <= MPA_WS_COLLECT;
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awReady_ff <= 1'b1;
      wReady_ff <= 1'b1;
      bValid_ff <= 1'b0;
      bResp_ff <= RESP_OKAY;
    end else begin
      wState_ff <= nxt_wState;
      awHeld_ff <= nxt_awHeld;
      wHeld_ff <= nxt_wHeld;
      awReady_ff <= ~nxt_awHeld & (nxt_wState == MPA_WS_COLLECT);
      wReady_ff <= ~nxt_wHeld & (nxt_wState == MPA_WS_COLLECT);
      bValid_ff <= nxt_wState == MPA_WS_RESP;
      if (doWrite) begin
        bResp_ff <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      awIdx_ff <= '0;
      wData_ff <= '0;
      wLane0_ff <= 1'b0;
    end else begin
      if (awTake) begin
        awIdx_ff <= s_axi_awaddr[ADDR_W-1:2];
      end
      if (wTake) begin
        wData_ff <= s_axi_wdata[PORT_W-1:0];
        wLane0_ff <= s_axi_wstrb[0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      arReady_ff <= 1'b1;
      rValid_ff <= 1'b0;
      rData_ff <= '0;
      rResp_ff <= RESP_OKAY;
    end else begin
      rValid_ff <= nxt_rValid;
      arReady_ff <= ~nxt_rValid;
      if (arTake) begin
        rData_ff <= {{(DATA_W - PORT_W){1'b0}}, rdByte};
        rResp_ff <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Side outputs for timer0, reset logic, converter and port B
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      timer0_ff <= 1'b0;
      clrPin_ff <= 1'b0;
      lowerAn_ff <= RST_ASEL[ASEL_LOW_LSB +: ASEL_LOW_W];
      portBAn_ff <= RST_ASEL[ASEL_PB_LSB +: ASEL_PB_W];
    end else begin
      timer0_ff <= padSync[PIN_OPEN_DRAIN];
      clrPin_ff <= padSync[PIN_INPUT_ONLY];
      lowerAn_ff <= aSel_ff[ASEL_LOW_LSB +: ASEL_LOW_W];
      // Port B forces its read to one while this is high
      portBAn_ff <= aSel_ff[ASEL_PB_LSB +: ASEL_PB_W];
    end
  end

  assign timer0ExternalClockIn = timer0_ff;
  assign masterClearIn = clrPin_ff;
  assign lowerAnalogMode = lowerAn_ff;
  assign portBAnalogMode = portBAn_ff;
  assign s_axi_awready = awReady_ff;
  assign s_axi_wready = wReady_ff;
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;
  assign s_axi_arready = arReady_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = rData_ff;
  assign s_axi_rresp = rResp_ff;

endmodule
`default_nettype wire

/* dv/mpa_port_a_chk.sv */
// Checker on the port A block's pin and bus ports
`timescale 1ns/100ps
`default_nettype none
module mpa_port_a_chk (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic otherResetPin,
  input wire logic oscUsesOutPin,
  input wire logic oscUsesInPin,
  input wire logic [mpa_pkg::PORT_W-1:0] periphEnable,
  input wire logic [mpa_pkg::PORT_W-1:0] padIn,
  input wire logic [mpa_pkg::PORT_W-1:0] padOut,
  input wire logic [mpa_pkg::PORT_W-1:0] padOe,
  input wire logic timer0ExternalClockIn,
  input wire logic masterClearIn,
  input wire logic [mpa_pkg::ASEL_LOW_W-1:0] lowerAnalogMode,
  input wire logic [mpa_pkg::ASEL_PB_W-1:0] portBAnalogMode,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [mpa_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp
);
  import mpa_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_input_only_pin: assert property (!padOe[PIN_INPUT_ONLY])
    else $error("input only pin driven");
  a_open_drain_low: assert property (!padOut[PIN_OPEN_DRAIN])
    else $error("open drain pin drives high");
  a_periph_owns_pin: assert property ((periphEnable & padOe &
    $past(periphEnable) & $past(periphEnable, 2)) == 8'h00)
    else $error("port drives a peripheral pin");
  a_osc_owns_pin: assert property
    (oscUsesOutPin [*3] |-> !padOe[PIN_OSC_OUT])
    else $error("port drives oscillator pin");
  a_osc_in_pin: assert property
    (oscUsesInPin [*3] |-> !padOe[PIN_OSC_IN])
    else $error("port drives oscillator input pin");
  a_timer_clk_pin: assert property
    ($stable(padIn[PIN_OPEN_DRAIN]) [*5] |->
    timer0ExternalClockIn == padIn[PIN_OPEN_DRAIN])
    else $error("timer clock input not following pin");
  a_clear_pin: assert property
    ($stable(padIn[PIN_INPUT_ONLY]) [*5] |->
    masterClearIn == padIn[PIN_INPUT_ONLY])
    else $error("master clear input not following pin");
  a_por_analog: assert property ($rose(reset_n) |->
    lowerAnalogMode == 4'hf && portBAnalogMode == 2'h3)
    else $error("analog select not set by power-on reset");
  a_other_rst_analog: assert property (otherResetPin [*6] |->
    lowerAnalogMode == 4'hf && portBAnalogMode == 2'h3)
    else $error("analog select not set by other reset");
  a_other_rst_dir: assert property
    (otherResetPin [*6] |-> padOe == 8'h00)
    else $error("pins driven during other reset");
  a_read_answer: assert property
    (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_write_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
endmodule
bind mpa_port_a mpa_port_a_chk chk (.*);
`default_nettype wire

/* dv/mpa_board.sv */
// Board circuitry model on the port A pins
`timescale 1ns/100ps
`default_nettype none
module mpa_board (
  input wire logic ref_clk,
  input wire logic [7:0] padOut,
  input wire logic [7:0] padOe,
  input wire logic [7:0] boardVal,
  input wire logic [7:0] boardEn,
  output logic [7:0] padIn
);
  import mpa_pkg::*;
  logic [7:0] lastLvl = 8'h00;
  logic [7:0] idle;
  // Undriven pins float: show the inverse rather than a stale level; the open-drain pin reads high
  always_comb begin
    idle = ~lastLvl;
    idle[PIN_OPEN_DRAIN] = 1'b1;
  end
  assign padIn = (padOe & padOut) | (~padOe & boardEn & boardVal) |
    (~padOe & ~boardEn & idle);
  always_ff @(posedge ref_clk) lastLvl <= padIn;
endmodule
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the port A block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import mpa_pkg::*;
  typedef struct {
    logic w;
    logic [11:0] a;
    logic [7:0] d;
    logic [3:0] st;
    logic [7:0] e;
    logic [1:0] rs;
  } mpa_row_s;
  logic ref_clk = 1'b0, reset_n = 1'b0, otherResetPin = 1'b0;
  logic oscUsesOutPin = 1'b0, oscUsesInPin = 1'b0;
  logic [7:0] periphEnable = 8'h00, padIn, padOut, padOe;
  logic timer0ExternalClockIn, masterClearIn;
  logic [3:0] lowerAnalogMode, s_axi_wstrb = 4'h0;
  logic [1:0] portBAnalogMode, s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd32;
  int failures = 0, checksDone = 0, cycles = 0;
  // Rows: write?, address, data, strobe, expected read, response
  mpa_row_s rows [18] = '{
    '{0, 12'h214, 8'h00, 4'h0, 8'hff, 2'h0},
    '{0, 12'h274, 8'h00, 4'h0, 8'h3f, 2'h0},
    '{0, 12'h014, 8'h00, 4'h0, 8'hb0, 2'h0},
    '{0, 12'h100, 8'h00, 4'h0, 8'h00, 2'h2},
    '{1, 12'h100, 8'h55, 4'hf, 8'h00, 2'h2},
    '{1, 12'h274, 8'h00, 4'h1, 8'h00, 2'h0},
    '{0, 12'h014, 8'h00, 4'h0, 8'hb5, 2'h0},
    '{1, 12'h014, 8'h2f, 4'h1, 8'h00, 2'h0},
    '{0, 12'h014, 8'h00, 4'h0, 8'hb5, 2'h0},
    '{1, 12'h214, 8'h00, 4'h1, 8'h00, 2'h0},
    '{0, 12'h014, 8'h00, 4'h0, 8'h2f, 2'h0},
    '{1, 12'h214, 8'h0f, 4'h1, 8'h00, 2'h0},
    '{0, 12'h014, 8'h00, 4'h0, 8'h25, 2'h0},
    '{1, 12'h014, 8'hff, 4'h0, 8'h00, 2'h0},
    '{1, 12'h214, 8'h00, 4'h1, 8'h00, 2'h0},
    '{0, 12'h014, 8'h00, 4'h0, 8'h25, 2'h0},
    '{0, 12'h214, 8'h00, 4'h0, 8'h00, 2'h0},
    '{0, 12'h274, 8'h00, 4'h0, 8'h00, 2'h0}};
  mpa_port_a uut (.*);
  mpa_board board (.ref_clk(ref_clk), .padOut(padOut), .padOe(padOe),
    .boardVal(8'ha5), .boardEn(8'hef), .padIn(padIn));
  always #25 ref_clk = ~ref_clk;
  task automatic results;
    if (failures == 0 && checksDone > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      results;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // Lag holds bready low for that many cycles of a standing bvalid
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
      input logic [3:0] st, output logic [1:0] r, input int lag = 0);
    logic aw, w, b;
    b = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    while (!b) begin
      @(negedge ref_clk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid & s_axi_bready;
      if (s_axi_bvalid && lag > 0) lag--;
      r = s_axi_bresp;
      @(posedge ref_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (lag == 0 && !b) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    // Pin sync and driver register settle before the next look
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
      output logic [1:0] r, input int lag = 0);
    logic ar, v;
    v = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    while (!v) begin
      @(negedge ref_clk);
      ar = s_axi_arvalid & s_axi_arready;
      v = s_axi_rvalid & s_axi_rready;
      if (s_axi_rvalid && lag > 0) lag--;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge ref_clk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (lag == 0 && !v) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [7:0] e);
    rd(a, rd32, rs);
    chk(rd32, {24'h000000, e});
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d, rows[i].st, rs);
      else rd(rows[i].a, rd32, rs);
      chk({30'h0, rs}, {30'h0, rows[i].rs});
      if (!rows[i].w) chk(rd32, {24'h0, rows[i].e});
    end
    wr(12'h274, 8'h01, 4'h1, rs);
    chk({30'h0, padOe[0], padOut[0]}, 32'h3);
    rdChk(12'h014, 8'h24);
    wr(12'h214, 8'h01, 4'h1, rs);
    chk({31'h0, padOe[0]}, 32'h0);
    periphEnable <= 8'h08;
    repeat (3) @(posedge ref_clk);
    chk({31'h0, padOe[3]}, 32'h0);
    periphEnable <= 8'h00;
    oscUsesOutPin <= 1'b1;
    oscUsesInPin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk({31'h0, padOe[PIN_OSC_OUT]}, 32'h0);
    chk({31'h0, padOe[PIN_OSC_IN]}, 32'h0);
    oscUsesOutPin <= 1'b0;
    oscUsesInPin <= 1'b0;
    otherResetPin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    otherResetPin <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rdChk(12'h214, 8'hff);
    rdChk(12'h274, 8'h3f);
    wr(12'h214, 8'h00, 4'h1, rs, 2);
    chk({28'h0, padOut[3:0]}, 32'h0);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({24'h0, padOe}, 32'h0);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rd(12'h214, rd32, rs, 3);
    chk(rd32, 32'h000000ff);
    results;
  end
endmodule
`default_nettype wire
